// file: hdl/uart_ctrl_defs.vh
// Register offsets, field positions and reset values of the serial port control block.
`ifndef UART_CTRL_DEFS_VH
`define UART_CTRL_DEFS_VH
// ==========================================================
// Register offsets (byte addresses on the 16-bit I/O bus).
`define OFS_DATA 16'h00C0
`define OFS_IEN 16'h00C1
`define OFS_QCTL 16'h00C2
`define OFS_LCTL 16'h00C3
`define OFS_ISTAT 16'h00C8
`define OFS_IMASK 16'h00C9
`define OFS_MODE 16'h00CA
// ==========================================================
// Field positions.
`define QC_EN 0
`define QC_RXFL 1
`define QC_TXFL 2
`define LC_DAS 7
`define LC_PEN 3
`define IE_RX 0
`define IE_TX 1
`define IE_LS 2
`define IE_MS 3
`define IE_TC 4
// ==========================================================
// Reset values.
`define QCTL_RST 8'h00
`define LCTL_RST 8'h00
`define IEN_RST 8'h00
`define DIV_RST 8'h00
// ==========================================================
// Cause codes.
`define CC_LS 3'h3
`define CC_RX 3'h2
`define CC_TO 3'h6
`define CC_TC 3'h5
`define CC_TE 3'h1
`define CC_MS 3'h0
`endif

// file: hdl/uart_irq_fifo_line_ctrl.v
// Interrupt identification, queue control and divisor access logic of a serial port.
// What this block does
// - Queue state field reads 00, 10 or 11
// - Cause code valid only with flag zero
// - Report only highest-priority active cause
// - Bit zero low while any cause active
// - Codes 011, 010, 110 for receive causes
// - Codes 101, 001, 000 for remaining causes
// - Read identification, write queue control, same address
// - Threshold codes select 1, 4, 8, 14 bytes
// - Bit two one flushes transmit queue
// - Bit one one flushes receive queues
// - Bit zero selects queues or single byte
// - Multi-node mode keeps receive queue disabled
// - Divisor access bit remaps shared addresses
// - Multi-node receive parity checked as space
// - Transmit complete needs both stages empty
// - Line status on parity, framing, overrun, break
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_defs.vh"
module uart_irq_fifo_line_ctrl #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	output reg irq,
	input wire rx_byte_valid,
	input wire [7:0] rx_byte,
	input wire [3:0] rx_err,
	input wire rx_timeout,
	input wire tx_byte_take,
	input wire tx_shift_empty,
	input wire modem_change,
	output reg tx_byte_valid,
	output reg [7:0] tx_byte,
	output reg rx_parity_space,
	output reg [7:0] baud_div_low,
	output reg [7:0] baud_div_high,
	output reg port_irq
);
	// ==========================================================
	// Register state.
	reg [7:0] qctl_reg; // Queue control: threshold, enable.
	reg [7:0] lctl_reg; // Line control.
	reg [7:0] ien_reg; // Interrupt enables.
	reg mode_reg; // Multi-node mode.
	reg [7:0] rxq [0:DEPTH-1]; // Receive queue storage.
	reg [7:0] txq [0:DEPTH-1]; // Transmit queue storage.
	reg [3:0] rxe [0:DEPTH-1]; // Receive error queue.
	reg [AW-1:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
	reg [AW:0] rx_cnt_reg, tx_cnt_reg;
	reg [5:0] ist_reg; // Sticky status of the six causes.
	reg [5:0] imask_reg; // Mask onto the system interrupt output.
	reg ms_reg; // Modem-change latch, cleared by an identification read whose cause code is 000.
	reg to_reg; // Time-out latch, cleared by a data read.
	reg [7:0] rdata_next;
	// Queue depth at the width of the counters, so no silent truncation happens at use.
	localparam [AW:0] DEPTH_W = DEPTH;
	// A single-byte holding stage, used when the queues are switched off.
	localparam [AW:0] ONE_W = 1;

	// ==========================================================
	// Effective depths: single byte when queues are off.
	wire q_en = qctl_reg[`QC_EN];
	wire rxq_en = q_en & ~mode_reg;
	wire [AW:0] rx_cap = rxq_en ? DEPTH_W : ONE_W;
	wire [AW:0] tx_cap = q_en ? DEPTH_W : ONE_W;
	wire das = lctl_reg[`LC_DAS];

	// Threshold decode, used for the receive cause.
	function [AW:0] thresh;
		input [1:0] code;
		begin
			case (code)
				2'h0: thresh = 5'h01;
				2'h1: thresh = 5'h04;
				2'h2: thresh = 5'h08;
				default: thresh = 5'h0E;
			endcase
		end
	endfunction

	wire acc_data = addr == `OFS_DATA;
	wire rd_rx = rd & acc_data & ~das;
	wire wr_tx = wr & acc_data & ~das;
	wire rx_pop = rd_rx & (rx_cnt_reg != 0);
	wire rx_push = rx_byte_valid & (rx_cnt_reg < rx_cap);
	wire tx_push = wr_tx & (tx_cnt_reg < tx_cap);
	wire tx_pop = tx_byte_take & (tx_cnt_reg != 0);
	wire qwr = wr & (addr == `OFS_QCTL);
	wire rx_flush = qwr & wdata[`QC_RXFL] & q_en;
	wire tx_flush = qwr & wdata[`QC_TXFL] & q_en;
	wire [3:0] head_err = rxe[rx_rp_reg];

	// ==========================================================
	// Live cause conditions, each gone once its source is removed.
	wire c_ls = ien_reg[`IE_LS] & (rx_cnt_reg != 0) & (|head_err);
	wire [AW:0] lvl = rxq_en ? thresh(qctl_reg[7:6]) : {{AW{1'b0}}, 1'b1};
	wire c_rx = ien_reg[`IE_RX] & (rx_cnt_reg >= lvl);
	wire c_to = ien_reg[`IE_RX] & to_reg;
	wire c_tc = ien_reg[`IE_TC] & (tx_cnt_reg == 0) & tx_shift_empty;
	wire c_te = ien_reg[`IE_TX] & (tx_cnt_reg == 0);
	wire c_ms = ien_reg[`IE_MS] & ms_reg;
	wire any_c = c_ls | c_rx | c_to | c_tc | c_te | c_ms;

	// Priority encoder; only the top cause is shown.
	reg [2:0] code;
	always @*
	begin
		if (c_ls) code = `CC_LS;
		else if (c_rx) code = `CC_RX;
		else if (c_to) code = `CC_TO;
		else if (c_tc) code = `CC_TC;
		else if (c_te) code = `CC_TE;
		else code = `CC_MS;
	end

	// Identification byte; the flag reads 1 when nothing is pending, as printed.
	wire [1:0] qstate = ~q_en ? 2'h0 : (mode_reg ? 2'h2 : 2'h3);
	wire [7:0] ident = {qstate, 2'h0, code, ~any_c};

	// ==========================================================
	// Read mux, answered one cycle after the strobe.
	always @*
	begin
		rdata_next = 8'h00;
		case (addr)
			`OFS_DATA: rdata_next = das ? baud_div_low : rxq[rx_rp_reg];
			`OFS_IEN: rdata_next = das ? baud_div_high : {3'h0, ien_reg[4:0]};
			`OFS_QCTL: rdata_next = ident;
			`OFS_LCTL: rdata_next = lctl_reg;
			`OFS_ISTAT: rdata_next = {2'h0, ist_reg};
			`OFS_IMASK: rdata_next = {2'h0, imask_reg};
			`OFS_MODE: rdata_next = {7'h00, mode_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// ==========================================================
	// Registers, queues and status. Sticky set beats write-one clear.
	wire [5:0] ev = {c_ms, c_te, c_tc, c_to, c_rx, c_ls};
	always @(posedge clk)
	begin
		if (rst)
		begin
			qctl_reg <= `QCTL_RST;
			lctl_reg <= `LCTL_RST;
			ien_reg <= `IEN_RST;
			baud_div_low <= `DIV_RST;
			baud_div_high <= `DIV_RST;
			mode_reg <= 1'b0;
			rx_wp_reg <= 0;
			rx_rp_reg <= 0;
			tx_wp_reg <= 0;
			tx_rp_reg <= 0;
			rx_cnt_reg <= 0;
			tx_cnt_reg <= 0;
			ist_reg <= 6'h00;
			imask_reg <= 6'h00;
			ms_reg <= 1'b0;
			to_reg <= 1'b0;
			rdata <= 8'h00;
			irq <= 1'b0;
			port_irq <= 1'b0;
			tx_byte_valid <= 1'b0;
			tx_byte <= 8'h00;
			rx_parity_space <= 1'b0;
		end
		else
		begin
			rdata <= rd ? rdata_next : 8'h00;
			if (qwr)
			begin
				// Flush bits are actions, so they are not stored.
				qctl_reg <= {wdata[7:6], 5'h00, wdata[`QC_EN]};
				if (wdata[`QC_EN] != q_en)
				begin
					// Depth change starts both queues empty.
					rx_wp_reg <= 0;
					rx_rp_reg <= 0;
					rx_cnt_reg <= 0;
					tx_wp_reg <= 0;
					tx_rp_reg <= 0;
					tx_cnt_reg <= 0;
				end
			end
			if (wr & addr == `OFS_LCTL) lctl_reg <= wdata;
			if (wr & addr == `OFS_IEN)
			begin
				if (das) baud_div_high <= wdata;
				else ien_reg <= {3'h0, wdata[4:0]};
			end
			if (wr & acc_data & das) baud_div_low <= wdata;
			if (wr & addr == `OFS_IMASK) imask_reg <= wdata[5:0];
			if (wr & addr == `OFS_MODE) mode_reg <= wdata[0];
			// Receive queue.
			if (rx_flush)
			begin
				rx_wp_reg <= 0;
				rx_rp_reg <= 0;
				rx_cnt_reg <= 0;
			end
			else if (!(qwr && wdata[`QC_EN] != q_en))
			begin
				if (rx_push)
				begin
					rxq[rx_wp_reg] <= rx_byte;
					rxe[rx_wp_reg] <= rx_err;
					rx_wp_reg <= (rx_cap == 1) ? rx_wp_reg : rx_wp_reg + 1'b1;
				end
				if (rx_pop) rx_rp_reg <= (rx_cap == 1) ? rx_rp_reg : rx_rp_reg + 1'b1;
				rx_cnt_reg <= rx_cnt_reg + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
			end
			// Transmit queue.
			if (tx_flush)
			begin
				tx_wp_reg <= 0;
				tx_rp_reg <= 0;
				tx_cnt_reg <= 0;
			end
			else if (!(qwr && wdata[`QC_EN] != q_en))
			begin
				if (tx_push)
				begin
					txq[tx_wp_reg] <= wdata;
					tx_wp_reg <= (tx_cap == 1) ? tx_wp_reg : tx_wp_reg + 1'b1;
				end
				if (tx_pop) tx_rp_reg <= (tx_cap == 1) ? tx_rp_reg : tx_rp_reg + 1'b1;
				tx_cnt_reg <= tx_cnt_reg + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
			end
			tx_byte_valid <= (tx_cnt_reg != 0) & ~tx_flush;
			tx_byte <= txq[tx_rp_reg];
			// Time-out held until data is read; modem change until an identification read returns cause code 000.
			if (rx_timeout) to_reg <= 1'b1;
			else if (rd_rx | rx_flush) to_reg <= 1'b0;
			if (modem_change) ms_reg <= 1'b1;
			else if (rd & addr == `OFS_QCTL & code == `CC_MS) ms_reg <= 1'b0;
			if (wr & addr == `OFS_ISTAT) ist_reg <= (ist_reg & ~wdata[5:0]) | ev;
			else ist_reg <= ist_reg | ev;
			irq <= |(ist_reg & imask_reg);
			port_irq <= any_c;
			rx_parity_space <= mode_reg & lctl_reg[`LC_PEN];
		end
	end
endmodule
`default_nettype wire

// file: tb/uart_ctrl_props.sv
// Port-level checker for the serial port control block.
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic port_irq,
	input wire logic tx_byte_valid,
	input wire logic tx_byte_take,
	input wire logic [7:0] baud_div_low,
	input wire logic [7:0] baud_div_high,
	input wire logic rx_parity_space
);
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Read data must idle at zero so a stale byte is never taken.
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	qstate_code_a: assert property ($past(rd && addr == 16'h00C2) |-> rdata[7:6] != 2'b01) else $error("bad qstate");
	cause_code_a: assert property ($past(rd && addr == 16'h00C2) |-> rdata[3:1] != 3'h4 && rdata[3:1] != 3'h7)
		else $error("bad cause code");
	flag_irq_a: assert property ($past(rd && addr == 16'h00C2) |-> rdata[0] != port_irq) else $error("flag vs irq");
	// A pop or an enable change empties the count first, so the valid flag drops one cycle later.
	tx_drain_a: assert property ($fell(tx_byte_valid) |-> $past(tx_byte_take, 2) || $past(wr && addr == 16'h00C2)
		|| $past(wr && addr == 16'h00C2, 2)) else $error("tx lost");
	div_low_a: assert property ($changed(baud_div_low) |-> $past(wr && addr == 16'h00C0)) else $error("div low");
	div_high_a: assert property ($changed(baud_div_high) |-> $past(wr && addr == 16'h00C1)) else $error("div high");
	// The parity output follows the stored mode bits one register stage later, two cycles behind the write.
	parity_space_a: assert property ($changed(rx_parity_space) |-> $past(wr && (addr == 16'h00C3 || addr == 16'h00CA), 2))
		else $error("parity mode");
endmodule
bind uart_irq_fifo_line_ctrl uart_ctrl_props uart_ctrl_props_inst (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd),
	.rdata(rdata), .port_irq(port_irq), .tx_byte_valid(tx_byte_valid), .tx_byte_take(tx_byte_take),
	.baud_div_low(baud_div_low), .baud_div_high(baud_div_high), .rx_parity_space(rx_parity_space));
`default_nettype wire

// file: tb/serial_peer.sv
// Model of the remote serial device feeding both paths.
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
	input wire logic clk,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic [3:0] rx_err,
	output logic rx_timeout,
	output logic tx_byte_take,
	output logic tx_shift_empty,
	output logic modem_change
);
	// ==========
	// Line state
	initial
	begin
		{rx_byte_valid, rx_timeout, tx_byte_take, modem_change} = 4'h0;
		{rx_byte, rx_err} = 12'h000;
		tx_shift_empty = 1'b1;
	end
	// Between characters the data shows its inverse, never a stale copy.
	task send(input logic [7:0] b, input logic [3:0] e);
		@(posedge clk);
		{rx_byte_valid, rx_byte, rx_err} <= {1'b1, b, e};
		@(posedge clk);
		{rx_byte_valid, rx_byte, rx_err} <= {1'b0, ~b, ~e};
	endtask
	// One-cycle time-out and modem-change events.
	task pulse(input logic t, input logic m);
		@(posedge clk);
		{rx_timeout, modem_change} <= {t, m};
		@(posedge clk);
		{rx_timeout, modem_change} <= 2'b00;
	endtask
	// The shifter takes a byte and stays busy from then on.
	task take;
		@(posedge clk);
		{tx_byte_take, tx_shift_empty} <= 2'b10;
		@(posedge clk);
		tx_byte_take <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, rst, wr, rd, rd_d, irq, port_irq, tx_byte_valid, rx_parity_space;
	logic [15:0] addr;
	logic [7:0] wdata, b, rdata, tx_byte, baud_div_low, baud_div_high;
	wire rx_byte_valid, rx_timeout, tx_byte_take, tx_shift_empty, modem_change;
	wire [7:0] rx_byte;
	wire [3:0] rx_err;
	logic [15:0] exp_q[$];
	logic [7:0] fb[$];
	int n_errors, samples_checked, i;
	uart_irq_fifo_line_ctrl uart_irq_fifo_line_ctrl_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq,
		.rx_byte_valid, .rx_byte, .rx_err, .rx_timeout, .tx_byte_take, .tx_shift_empty, .modem_change,
		.tx_byte_valid, .tx_byte, .rx_parity_space, .baud_div_low, .baud_div_high, .port_irq);
	serial_peer peer_inst (.clk, .rx_byte_valid, .rx_byte, .rx_err, .rx_timeout, .tx_byte_take, .tx_shift_empty,
		.modem_change);
	// ==========
	// Bus tasks and checks
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr8(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// The expected byte is queued with a mask of bits that matter.
	task rd8(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		exp_q.push_back({m, e});
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task finish_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe.
	always @(posedge clk)
	begin
		rd_d <= rd;
		if (rd_d)
		begin
			if (exp_q.size() == 0)
			begin
				n_errors++;
				$display("[ERR] rdata expected a queued note seen none");
			end
			else
			begin
				chk("rdata", exp_q[0][7:0], rdata & exp_q[0][15:8]);
				void'(exp_q.pop_front());
			end
		end
	end
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// ==========
	// Main sequence
	initial
	begin
		{rst, wr, rd, addr, wdata, n_errors, samples_checked} = {3'h4, 24'h0, 64'h0};
		void'($urandom(38));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd8(16'h00C2, 8'h01);
		wr8(16'h00C1, 8'h02);
		rd8(16'h00C2, 8'h02);
		wr8(16'h00C1, 8'h12);
		rd8(16'h00C2, 8'h0A);
		b = 8'($urandom);
		wr8(16'h00C0, b);
		rd8(16'h00C2, 8'h01);
		chk("tx_byte", b, tx_byte);
		peer_inst.take();
		rd8(16'h00C2, 8'h02);
		wr8(16'h00C1, 8'h01);
		wr8(16'h00C2, 8'h41);
		for (i = 0; i < 4; i++)
		begin
			fb.push_back(8'($urandom));
			peer_inst.send(fb[i], 4'h0);
			if (i == 2)
				rd8(16'h00C2, 8'hC1);
		end
		rd8(16'h00C2, 8'hC4);
		rd8(16'h00C0, fb[0]);
		rd8(16'h00C2, 8'hC1);
		wr8(16'h00C2, 8'h43);
		for (i = 0; i < 3; i++)
			peer_inst.send(8'($urandom), 4'h0);
		rd8(16'h00C2, 8'hC1);
		wr8(16'h00C1, 8'h05);
		// Empty the queue so the errored byte is at the head.
		wr8(16'h00C2, 8'h43);
		peer_inst.send(8'h5A, 4'h1);
		rd8(16'h00C2, 8'hC6);
		wr8(16'h00CA, 8'h01);
		wr8(16'h00C3, 8'h08);
		rd8(16'h00C2, 8'h80, 8'hC0);
		chk("parity", 8'h01, {7'h00, rx_parity_space});
		b = 8'($urandom);
		wr8(16'h00C3, 8'h80);
		wr8(16'h00C0, b);
		wr8(16'h00C1, ~b);
		rd8(16'h00C3, 8'h80);
		chk("div_low", b, baud_div_low);
		chk("div_high", ~b, baud_div_high);
		wr8(16'h00C8, 8'h3F);
		wr8(16'h00C9, 8'h00);
		peer_inst.send(8'hA5, 4'h2);
		repeat (2) @(posedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		wr8(16'h00C9, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", 8'h01, {7'h00, irq});
		// Remove the line status source by reading the errored byte, then clear its status.
		wr8(16'h00C3, 8'h00);
		rd8(16'h00C0, 8'h5A);
		wr8(16'h00C8, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		// Time-out cause, then cleared by a data read.
		peer_inst.pulse(1'b1, 1'b0);
		rd8(16'h00C2, 8'h8C);
		rd8(16'h00C0, 8'h00, 8'h00);
		rd8(16'h00C2, 8'h81);
		// Modem cause, cleared by reading the identification while it shows.
		wr8(16'h00C1, 8'h08);
		peer_inst.pulse(1'b0, 1'b1);
		rd8(16'h00C2, 8'h80);
		rd8(16'h00C2, 8'h81);
		rd8(16'h00CF, 8'h00);
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule
`default_nettype wire
